// ==== core/hps_pkg.sv ====
// Package with register map, field layout, timing constants and carriers for the playback engine.
package hps_pkg;
    localparam int HPS_CLK_HZ = 25000000;
    localparam int HPS_STEP_SLOW_US = 5000;
    localparam int HPS_STEP_FAST_US = 1000;
    localparam int HPS_WAIT_UNIT_US = 10000;
    localparam int HPS_STEP_SLOW_CYC = HPS_CLK_HZ / 1000000 * HPS_STEP_SLOW_US;
    localparam int HPS_STEP_FAST_CYC = HPS_CLK_HZ / 1000000 * HPS_STEP_FAST_US;
    localparam int HPS_WAIT_UNIT_CYC = HPS_CLK_HZ / 1000000 * HPS_WAIT_UNIT_US;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] HPS_IDX_LAUNCH = 8'h0C;
    localparam logic [7:0] HPS_IDX_STEP_GAIN = 8'h0D;
    localparam logic [7:0] HPS_IDX_SAMPLE = 8'h0E;
    localparam logic [7:0] HPS_IDX_SLOT_FIRST = 8'h0F;
    localparam logic [7:0] HPS_IDX_SLOT_LAST = 8'h16;
    localparam logic [7:0] HPS_IDX_MODE = 8'h20;
    localparam logic [7:0] HPS_IDX_STATUS = 8'h21;
    localparam int HPS_NUM_SLOTS = 8;

    localparam logic [7:0] HPS_RST_STEP_GAIN = 8'h00;
    localparam logic [7:0] HPS_RST_SAMPLE = 8'h7F;
    localparam logic [7:0] HPS_RST_SLOT_FIRST = 8'h01;
    localparam logic [7:0] HPS_RST_SLOT_OTHER = 8'h00;

    localparam logic [7:0] HPS_MASK_STEP_GAIN = 8'h23;
    localparam int HPS_BIT_STEP_FAST = 5;
    localparam int HPS_BIT_DELAY_FLAG = 7;
    localparam logic [6:0] HPS_SLOT_END = 7'h00;

    localparam logic [1:0] HPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] HPS_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        HPS_MODE_SEQUENCE,
        HPS_MODE_LIVE,
        HPS_MODE_CALIB,
        HPS_MODE_DIAG
    } hps_mode_t;

    typedef struct packed {
        logic step_fast;
        logic [1:0] attenuation;
        hps_mode_t mode;
    } hps_cfg_t;

    typedef struct packed {
        logic valid;
        logic [6:0] effect_id;
        logic signed [7:0] amplitude;
    } hps_drive_t;
endpackage

// ==== core/hps_attenuator.sv ====
// Amplitude scaler for library effects, bypassed for live samples.
`timescale 1ns/1ns
`default_nettype none
module hps_attenuator
    import hps_pkg::*;
(
    input wire logic signed [7:0] sample,
    input wire logic [1:0] attenuation,
    input wire logic bypass,
    output logic signed [7:0] scaled
);
    logic signed [9:0] wide;
    logic signed [9:0] half;
    logic signed [9:0] quarter;

    always_comb begin
        wide = 10'(sample);
        half = wide >>> 1;
        quarter = wide >>> 2;
        if (bypass) begin
            scaled = sample;
        end else begin
            case (attenuation)
                2'h0: scaled = sample;
                2'h1: scaled = 8'(half + quarter);
                2'h2: scaled = 8'(half);
                2'h3: scaled = 8'(quarter);
                default: scaled = sample;
            endcase
        end
    end
endmodule // hps_attenuator
`default_nettype wire

// ==== core/hps_tick.sv ====
// Programmable period tick generator used for playback steps; wait units are counted in the sequencer.
`timescale 1ns/1ns
`default_nettype none
module hps_tick #(
    parameter int SLOW_CYC = 125000,
    parameter int FAST_CYC = 25000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic run,
    input wire logic fast,
    output logic tick
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic [31:0] limit;

    always_comb begin
        limit = fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
        tick = run && (count >= limit);
        if (!run || tick) begin
            next_count = 32'h00000000;
        end else begin
            next_count = count + 32'h00000001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 32'h00000000;
        end else if (ce) begin
            count <= next_count;
        end
    end
endmodule // hps_tick
`default_nettype wire

// ==== core/hps_sequencer.sv ====
// Playback sequencer front end with AXI4-Lite register slave, slot walker and live drive.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Library steps tick every 5 ms, or every 1 ms with the fast step bit.
// - Attenuation code scales library amplitude to 100, 75, 50 or 25 percent.
// - Live drive samples bypass the attenuator.
// - Launched live drive puts the current sample on the drive output.
// - The sample register is an eight-bit signed amplitude.
// - Host may rewrite the sample anytime; each new value reaches the output.
// - Delay flag makes a slot idle for its value times 10 ms.
// - Clear delay flag makes the slot value an effect identifier.
// - Identifier indexes the effect library directly.
// - Launch starts playback at the first slot.
// - After a slot finishes, the next slot plays if nonzero.
// - Sequencer stops after all eight slots.
// - A zero identifier stops the sequencer without playing.
// - Launch bit stays set while running and clears on completion.
// - Clearing launch bit aborts the running process immediately.
// - External trigger sets the launch bit like a write of one.
// - Mode setting picks which process the launch bit starts.
module hps_sequencer
    import hps_pkg::*;
#(
    parameter int STEP_SLOW_CYC = HPS_STEP_SLOW_CYC,
    parameter int STEP_FAST_CYC = HPS_STEP_FAST_CYC,
    parameter int WAIT_UNIT_CYC = HPS_WAIT_UNIT_CYC,
    parameter int EFFECT_STEPS = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_trigger,
    input wire logic signed [7:0] library_sample,
    input wire logic process_done,
    output hps_drive_t drive,
    output logic step_tick
);
    typedef enum {HPS_IDLE, HPS_SLOT, HPS_PLAY, HPS_WAIT, HPS_LIVE, HPS_OTHER} hps_state_t;

    // Register state.
    hps_cfg_t cfg, next_cfg;
    logic [7:0] sample, next_sample;
    logic [7:0] slots [HPS_NUM_SLOTS];
    logic [7:0] next_slots [HPS_NUM_SLOTS];
    logic launch, next_launch;
    // Bus state.
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, bad_w, next_bad_w;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic bad_r, next_bad_r;
    // Sequencer state.
    hps_state_t state, next_state;
    logic [2:0] slot_idx, next_slot_idx;
    logic [6:0] wait_units, next_wait_units;
    logic [31:0] unit_cnt, next_unit_cnt;
    logic [7:0] step_cnt, next_step_cnt;
    hps_drive_t next_drive;
    logic signed [7:0] scaled;
    logic playing, done_now, abort;
    logic do_write, wr_launch_clr;
    logic [5:0] w_idx, r_idx;
    logic [7:0] wbyte;

    hps_tick #(.SLOW_CYC(STEP_SLOW_CYC), .FAST_CYC(STEP_FAST_CYC)) u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .run(playing),
        .fast(cfg.step_fast),
        .tick(step_tick)
    );

    hps_attenuator u_atten (
        .sample(state == HPS_LIVE ? $signed(sample) : library_sample),
        .attenuation(cfg.attenuation),
        .bypass(state == HPS_LIVE),
        .scaled(scaled)
    );

    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bad_w ? HPS_RESP_SLVERR : HPS_RESP_OKAY;
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = bad_r ? HPS_RESP_SLVERR : HPS_RESP_OKAY;
    assign playing = (state == HPS_PLAY);

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (8'(idx) >= HPS_IDX_LAUNCH && 8'(idx) <= HPS_IDX_SLOT_LAST)
            || 8'(idx) == HPS_IDX_MODE || 8'(idx) == HPS_IDX_STATUS;
    endfunction

    // Bus channel and register write logic.
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bad_w = bad_w;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_bad_r = bad_r;
        next_cfg = cfg;
        next_sample = sample;
        for (int i = 0; i < HPS_NUM_SLOTS; i++) begin
            next_slots[i] = slots[i];
        end
        wr_launch_clr = 1'b0;
        next_launch = launch;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held;
        w_idx = aw_addr[7:2];
        wbyte = w_data[7:0];
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bad_w = !mapped(w_idx);
            if (w_strb[0]) begin
                case (8'(w_idx))
                    HPS_IDX_LAUNCH: begin
                        next_launch = wbyte[0];
                        wr_launch_clr = !wbyte[0];
                    end
                    HPS_IDX_STEP_GAIN: begin
                        next_cfg.step_fast = wbyte[HPS_BIT_STEP_FAST];
                        next_cfg.attenuation = wbyte[1:0];
                    end
                    HPS_IDX_SAMPLE: next_sample = wbyte;
                    HPS_IDX_MODE: next_cfg.mode = hps_mode_t'(wbyte[1:0]);
                    default: begin
                        if (8'(w_idx) >= HPS_IDX_SLOT_FIRST && 8'(w_idx) <= HPS_IDX_SLOT_LAST) begin
                            next_slots[3'(8'(w_idx) - HPS_IDX_SLOT_FIRST)] = wbyte;
                        end
                    end
                endcase
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (ext_trigger) begin
            next_launch = 1'b1;
        end
        // A trigger or a host write of the launch bit in the completion cycle wins over the clear.
        if (done_now && !ext_trigger && !(do_write && w_strb[0] && 8'(w_idx) == HPS_IDX_LAUNCH)) begin
            next_launch = 1'b0;
        end
        r_idx = s_axi_araddr[7:2];
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_bad_r = !mapped(r_idx);
            next_rdata = 32'h00000000;
            case (8'(r_idx))
                HPS_IDX_LAUNCH: next_rdata[0] = launch;
                HPS_IDX_STEP_GAIN: next_rdata[7:0] = {2'h0, cfg.step_fast, 3'h0, cfg.attenuation};
                HPS_IDX_SAMPLE: next_rdata[7:0] = sample;
                HPS_IDX_MODE: next_rdata[1:0] = cfg.mode;
                HPS_IDX_STATUS: next_rdata[7:0] = {2'h0, playing, state == HPS_WAIT, 1'b0, slot_idx};
                default: begin
                    if (8'(r_idx) >= HPS_IDX_SLOT_FIRST && 8'(r_idx) <= HPS_IDX_SLOT_LAST) begin
                        next_rdata[7:0] = slots[3'(8'(r_idx) - HPS_IDX_SLOT_FIRST)];
                    end
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Sequencer walk and drive output.
    always_comb begin
        next_state = state;
        next_slot_idx = slot_idx;
        next_wait_units = wait_units;
        next_unit_cnt = unit_cnt;
        next_step_cnt = step_cnt;
        next_drive = drive;
        done_now = 1'b0;
        abort = !launch || wr_launch_clr;
        case (state)
            HPS_IDLE: begin
                next_drive = '0;
                if (launch) begin
                    next_slot_idx = 3'h0;
                    case (cfg.mode)
                        HPS_MODE_SEQUENCE: next_state = HPS_SLOT;
                        HPS_MODE_LIVE: next_state = HPS_LIVE;
                        default: next_state = HPS_OTHER;
                    endcase
                end
            end
            HPS_SLOT: begin
                if (slots[slot_idx][HPS_BIT_DELAY_FLAG]) begin
                    next_wait_units = slots[slot_idx][6:0];
                    next_unit_cnt = 32'h00000000;
                    next_state = HPS_WAIT;
                end else if (slots[slot_idx][6:0] == HPS_SLOT_END) begin
                    done_now = 1'b1;
                    next_state = HPS_IDLE;
                end else begin
                    next_step_cnt = 8'h00;
                    next_state = HPS_PLAY;
                end
            end
            HPS_PLAY: begin
                next_drive.valid = 1'b1;
                next_drive.effect_id = slots[slot_idx][6:0];
                next_drive.amplitude = scaled;
                if (step_tick) begin
                    next_step_cnt = step_cnt + 8'h01;
                end
                if (step_tick && step_cnt == 8'(EFFECT_STEPS - 1)) begin
                    next_state = HPS_SLOT;
                end
            end
            HPS_WAIT: begin
                next_drive = '0;
                if (wait_units == 7'h00) begin
                    next_state = HPS_SLOT;
                end else if (unit_cnt == 32'(WAIT_UNIT_CYC - 1)) begin
                    next_unit_cnt = 32'h00000000;
                    next_wait_units = wait_units - 7'h01;
                end else begin
                    next_unit_cnt = unit_cnt + 32'h00000001;
                end
            end
            HPS_LIVE: begin
                next_drive.valid = 1'b1;
                next_drive.effect_id = 7'h00;
                next_drive.amplitude = scaled;
            end
            HPS_OTHER: begin
                next_drive = '0;
                if (process_done) begin
                    done_now = 1'b1;
                    next_state = HPS_IDLE;
                end
            end
            default: next_state = HPS_IDLE;
        endcase
        if (state == HPS_PLAY || state == HPS_WAIT) begin
            if (next_state == HPS_SLOT) begin
                if (slot_idx == 3'(HPS_NUM_SLOTS - 1)) begin
                    done_now = 1'b1;
                    next_state = HPS_IDLE;
                end else begin
                    next_slot_idx = slot_idx + 3'h1;
                end
            end
        end
        if (state != HPS_IDLE && abort) begin
            next_state = HPS_IDLE;
            next_drive = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bad_w <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            bad_r <= 1'b0;
            cfg <= '{step_fast: HPS_RST_STEP_GAIN[HPS_BIT_STEP_FAST],
                attenuation: HPS_RST_STEP_GAIN[1:0], mode: HPS_MODE_SEQUENCE};
            sample <= HPS_RST_SAMPLE;
            slots[0] <= HPS_RST_SLOT_FIRST;
            for (int i = 1; i < HPS_NUM_SLOTS; i++) begin
                slots[i] <= HPS_RST_SLOT_OTHER;
            end
            launch <= 1'b0;
            state <= HPS_IDLE;
            slot_idx <= 3'h0;
            wait_units <= 7'h00;
            unit_cnt <= 32'h00000000;
            step_cnt <= 8'h00;
            drive <= '0;
        end else if (ce) begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bad_w <= next_bad_w;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            bad_r <= next_bad_r;
            cfg <= next_cfg;
            sample <= next_sample;
            slots <= next_slots;
            launch <= next_launch;
            state <= next_state;
            slot_idx <= next_slot_idx;
            wait_units <= next_wait_units;
            unit_cnt <= next_unit_cnt;
            step_cnt <= next_step_cnt;
            drive <= next_drive;
        end
    end
endmodule // hps_sequencer
`default_nettype wire

// ==== sim/hps_sequencer_asserts.sv ====
// Checker for bus handshakes and playback step timing of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module hps_seq_chk
    import hps_pkg::*;
#(
    parameter int STEP_FAST_CYC = HPS_STEP_FAST_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_tick
);
    int gap;
    logic seen;

    // Gap holds the cycles since the previous tick, up to 100000, at the cycle a tick arrives.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap <= 0;
            seen <= 1'b0;
        end else if (step_tick) begin
            gap <= 1;
            seen <= 1'b1;
        end else if (gap < 100000) begin
            gap <= gap + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data without request");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == HPS_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("refused read returns data");
    a_tick_pulse: assert property (step_tick |=> !step_tick)
        else $error("step tick longer than a cycle");
    a_tick_gap: assert property (step_tick && seen |-> gap >= STEP_FAST_CYC)
        else $error("step ticks too close");
endmodule // hps_seq_chk

bind hps_sequencer hps_seq_chk #(.STEP_FAST_CYC(STEP_FAST_CYC)) hps_seq_chk_i (
    .clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .step_tick
);
`default_nettype wire

// ==== sim/hps_library_model.sv ====
// Effect library and process completion model at the far side of the engine.
`timescale 1ns/1ns
`default_nettype none
module hps_library_model
    import hps_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire hps_drive_t drive,
    input wire logic finish,
    output logic signed [7:0] library_sample,
    output logic process_done
);
    // Each library entry plays its own index as amplitude.
    assign library_sample = {1'b0, drive.effect_id};

    always @(posedge clk or negedge reset_n) begin
        process_done <= reset_n && finish;
    end
endmodule // hps_library_model
`default_nettype wire

// ==== sim/hps_sequencer_tb.sv ====
// Self-checking testbench for the playback sequencer.
`timescale 1ns/1ns
`default_nettype none
module hps_sequencer_tb
    import hps_pkg::*;
;
    localparam int SLOW = 50;
    localparam int FAST = 10;
    localparam int UNIT = 20;
    localparam logic [1:0] OK = HPS_RESP_OKAY;
    localparam logic [7:0] A_GO = HPS_IDX_LAUNCH << 2;
    localparam logic [7:0] A_GAIN = HPS_IDX_STEP_GAIN << 2;
    localparam logic [7:0] A_SMP = HPS_IDX_SAMPLE << 2;
    localparam logic [7:0] A_SLOT = HPS_IDX_SLOT_FIRST << 2;
    localparam logic [7:0] A_MODE = HPS_IDX_MODE << 2;
    localparam logic [7:0] A_STAT = HPS_IDX_STATUS << 2;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_trigger = 1'b0, fin = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic step_tick, process_done;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic signed [7:0] library_sample;
    hps_drive_t drive;
    logic [7:0] amp [4] = '{8'h40, 8'h30, 8'h20, 8'h10};
    logic [6:0] ids [$];
    int n_errors = 0, checks = 0, gap = 0, last_gap = 0, i, n;

    always #20 clk = ~clk;

    hps_sequencer #(.STEP_SLOW_CYC(SLOW), .STEP_FAST_CYC(FAST), .WAIT_UNIT_CYC(UNIT),
        .EFFECT_STEPS(4)) hps_sequencer_i (
        .clk, .reset_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger,
        .library_sample, .process_done, .drive, .step_tick
    );
    hps_library_model hps_library_model_i (
        .clk, .reset_n, .drive, .finish(fin), .library_sample, .process_done
    );

    // Step period and the order of played effects.
    always @(posedge clk) begin
        last_gap <= step_tick ? gap : last_gap;
        gap <= step_tick ? 1 : gap + 1;
        if (drive.valid && (ids.size() == 0 || ids[$] !== drive.effect_id)) begin
            ids.push_back(drive.effect_id);
        end
    end

    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    task automatic hang();
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
        summarize();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 50);
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid) hang();
        chk_resp(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        int k;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 50);
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid) hang();
        v = s_axi_rdata;
        chk_resp(s_axi_rresp, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] v;
        rd(a, v, er);
        chk(v, exp);
    endtask

    // Reads the launch bit until it shows the expected value.
    task automatic poll(input logic [31:0] exp);
        logic [31:0] v;
        int k;
        k = 0;
        do begin
            rd(A_GO, v, OK);
            k++;
        end while (v !== exp && k < 400);
        chk(v, exp);
    endtask

    task automatic wait_v(input logic exp, input int b, output int c);
        c = 0;
        while (drive.valid !== exp && c < b) begin
            @(posedge clk);
            c++;
        end
        if (drive.valid !== exp) hang();
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rdc(A_GO, 32'h0, OK);
        rdc(A_GAIN, 32'h0, OK);
        rdc(A_SMP, 32'h7F, OK);
        rdc(A_SLOT, 32'h01, OK);
        wr(A_GAIN, 32'hFFFF_FFFF, OK);
        rdc(A_GAIN, 32'h23, OK);
        rdc(8'hFC, 32'h0, HPS_RESP_SLVERR);
        wr(8'hFC, 32'h1, HPS_RESP_SLVERR);
        wr(A_SLOT, 32'h40, OK);
        for (i = 0; i < 4; i++) begin
            wr(A_GAIN, {26'h0, i[0], 3'h0, i[1:0]}, OK);
            wr(A_GO, 32'h1, OK);
            wait_v(1'b1, 500, n);
            repeat (2) @(posedge clk);
            chk({24'h0, drive.amplitude}, {24'h0, amp[i]});
            chk({25'h0, drive.effect_id}, 32'h40);
            poll(32'h0);
            chk(last_gap, i[0] ? FAST : SLOW);
        end
        wr(A_SLOT, 32'h83, OK);
        wr(A_SLOT + 8'h04, 32'h05, OK);
        wr(A_GO, 32'h1, OK);
        rdc(A_STAT, 32'h10, OK);
        wait_v(1'b1, 200, n);
        chk({31'h0, n >= 3 * UNIT - 4 && n <= 3 * UNIT + 8}, 32'h1);
        repeat (2) @(posedge clk);
        chk({25'h0, drive.effect_id}, 32'h05);
        poll(32'h0);
        wr(A_GAIN, 32'h20, OK);
        for (i = 0; i < 8; i++) wr(A_SLOT + 8'(4 * i), i + 1, OK);
        ids.delete();
        wr(A_GO, 32'h1, OK);
        poll(32'h0);
        chk(ids.size(), 8);
        for (i = 0; i < 8; i++) chk({25'h0, ids[i]}, i + 1);
        wr(A_SLOT, 32'h00, OK);
        ids.delete();
        wr(A_GO, 32'h1, OK);
        poll(32'h0);
        chk(ids.size(), 0);
        wr(A_SLOT, 32'h40, OK);
        wr(A_GO, 32'h1, OK);
        wait_v(1'b1, 200, n);
        wr(A_GO, 32'h0, OK);
        repeat (2) @(posedge clk);
        chk({31'h0, drive.valid}, 32'h0);
        wr(A_MODE, 32'h1, OK);
        wr(A_GAIN, 32'h03, OK);
        wr(A_SMP, 32'h80, OK);
        wr(A_GO, 32'h1, OK);
        wait_v(1'b1, 50, n);
        repeat (2) @(posedge clk);
        chk({24'h0, drive.amplitude}, 32'h80);
        wr(A_SMP, 32'h12, OK);
        repeat (2) @(posedge clk);
        chk({24'h0, drive.amplitude}, 32'h12);
        wr(A_GO, 32'h0, OK);
        wait_v(1'b0, 10, n);
        wr(A_SLOT, 32'h00, OK);
        for (i = 2; i < 4; i++) begin
            wr(A_MODE, i, OK);
            ext_trigger <= 1'b1;
            @(posedge clk);
            ext_trigger <= 1'b0;
            rdc(A_GO, 32'h1, OK);
            repeat (30) @(posedge clk);
            rdc(A_GO, 32'h1, OK);
            fin <= 1'b1;
            @(posedge clk);
            fin <= 1'b0;
            poll(32'h0);
        end
        summarize();
    end
endmodule // hps_sequencer_tb
`default_nettype wire
